// ===== design/comparator_control_map.svh
// Register map, field positions, reset values and counts of the comparator
// channel control block. Assumes a 32-bit APB bus, one word per register.
`ifndef COMPARATOR_CONTROL_MAP_SVH
`define COMPARATOR_CONTROL_MAP_SVH

// ************************************************************
// Addressing
// ************************************************************
`define CCL_ADDR_W          12
`define CCL_CTRL_ADDR       12'h000
`define CCL_DATA_ZERO       32'h0000_0000
`define CCL_CTRL_RESET      14'h0000

// ************************************************************
// Control register bit positions
// ************************************************************
`define CCL_BIT_ON          15
`define CCL_BIT_IDLE_STOP   13
`define CCL_HYS_HI          12
`define CCL_HYS_LO          11
`define CCL_BIT_FILTER_EN   10
`define CCL_BIT_FCLK_SEL    9
`define CCL_BIT_DAC_OE      8
`define CCL_INPUT_SOURCE_SELECT_HI        7
`define CCL_INPUT_SOURCE_SELECT_LO        6
`define CCL_BIT_EXT_REF     5
`define CCL_BIT_HYS_EDGE    4
`define CCL_BIT_STATE       3
`define CCL_BIT_ALT_INPUT   2
`define CCL_BIT_INVERT      1
`define CCL_BIT_RANGE       0
`define CCL_LANE_LO         0
`define CCL_LANE_HI         1

// ************************************************************
// Input selection, one-hot towards the analog multiplexer
// ************************************************************
`define CCL_SEL_NONE        6'h00
`define CCL_SEL_PIN_A       6'h01
`define CCL_SEL_PIN_B       6'h02
`define CCL_SEL_PIN_C       6'h04
`define CCL_SEL_PIN_D       6'h08
`define CCL_SEL_AMP_1       6'h10
`define CCL_SEL_AMP_2       6'h20

// ************************************************************
// Stretcher and filter counts
// ************************************************************
`define CCL_STRETCH_LOAD    2'h2
`define CCL_COUNT_ZERO      2'h0
`define CCL_COUNT_ONE       2'h1
`define CCL_FILTER_LAST     2'h2

`endif

// ===== design/comparator_control_pkg.sv
// Types shared by the comparator channel control block.
// Assumes the constants of comparator_control_map.svh.
package comparator_control_pkg;

    // ************************************************************
    // Stored control fields
    // ************************************************************
    typedef struct packed {
        logic       comparator_on;
        logic       idle_stop;
        logic [1:0] hysteresis_level;
        logic       filter_enable;
        logic       filter_clock_select;
        logic       dac_pin_output_enable;
        logic [1:0] input_source_select;
        logic       external_reference_select;
        logic       hysteresis_edge;
        logic       alternate_input_select;
        logic       output_invert;
        logic       dac_range_supply;
    } ctrl_s;

    // Settings handed to the analog comparator and its DAC
    typedef struct packed {
        logic [1:0] hysteresis_level;
        logic       hysteresis_edge;
        logic       dac_pin_connect;
        logic       external_reference_select;
        logic       dac_range_supply;
        logic [5:0] input_select;
    } analog_cfg_s;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ACCESS = 2'b01
    } bus_state_e;

endpackage : comparator_control_pkg

// ===== design/comparator_level_filter.sv
// Digital glitch filter for the comparator output.
// Assumes i_step is a one-cycle qualifier from the selected filter clock.
`timescale 1ns/1ps
`include "comparator_control_map.svh"

module comparator_level_filter (
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    input  wire logic i_step,
    input  wire logic i_level,
    output logic      o_level
);

    logic [1:0] stable_count;

    // ************************************************************
    // Level qualification
    // ************************************************************
    // Any cycle that agrees with the output restarts the count, so a
    // level must differ on three filter steps without a break to pass.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            stable_count <= `CCL_COUNT_ZERO;
            o_level      <= 1'b0;
        end else if (i_level == o_level) begin
            stable_count <= `CCL_COUNT_ZERO;
        end else if (i_step) begin
            if (stable_count == `CCL_FILTER_LAST) begin
                o_level      <= i_level;
                stable_count <= `CCL_COUNT_ZERO;
            end else begin
                stable_count <= stable_count + `CCL_COUNT_ONE;
            end
        end
    end

endmodule : comparator_level_filter

// ===== design/comparator_control_logic.sv
// Control register and digital output path of one comparator channel.
// Assumes an APB master on i_clk_sys and a comparator output already
// synchronous to that clock; the PWM clock arrives as a one-cycle tick.
`timescale 1ns/1ps
`include "comparator_control_map.svh"

module comparator_control_logic (
    input  wire logic                                i_clk_sys,
    input  wire logic                                i_reset,
    input  wire logic                                i_psel,
    input  wire logic                                i_penable,
    input  wire logic                                i_pwrite,
    input  wire logic [`CCL_ADDR_W-1:0]              i_paddr,
    input  wire logic [31:0]                         i_pwdata,
    input  wire logic [3:0]                          i_pstrb,
    output logic      [31:0]                         o_prdata,
    output logic                                     o_pready,
    output logic                                     o_pslverr,
    input  wire logic                                i_idle_mode,
    input  wire logic                                i_other_idle_stop,
    input  wire logic                                i_pwm_clock_tick,
    input  wire logic                                i_comparator_raw,
    output logic                                     o_idle_stop,
    output logic                                     o_comparator_enable,
    output comparator_control_pkg::analog_cfg_s      o_analog_config,
    output logic                                     o_comparator_out
);

    comparator_control_pkg::ctrl_s      ctrl;
    comparator_control_pkg::bus_state_e bus_state;
    logic                               active;
    logic                               polarity_level;
    logic                               stretched;
    logic [1:0]                         stretch_count;
    logic                               step;
    logic                               filtered;
    logic                               bus_setup;
    logic                               bus_write;
    logic                               addr_hit;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Reserved alternate codes select nothing, so no input is connected
    function automatic logic [5:0] input_decode(input logic alt, input logic [1:0] sel);
        logic [5:0] onehot;
        onehot = `CCL_SEL_NONE;
        if (alt) begin
            case (sel)
                2'h0:    onehot = `CCL_SEL_AMP_1;
                2'h1:    onehot = `CCL_SEL_AMP_2;
                default: onehot = `CCL_SEL_NONE;
            endcase
        end else begin
            case (sel)
                2'h0:    onehot = `CCL_SEL_PIN_A;
                2'h1:    onehot = `CCL_SEL_PIN_B;
                2'h2:    onehot = `CCL_SEL_PIN_C;
                default: onehot = `CCL_SEL_PIN_D;
            endcase
        end
        return onehot;
    endfunction : input_decode

    // Read image; bit 14 and everything above bit 15 stay zero
    function automatic logic [31:0] read_image(input comparator_control_pkg::ctrl_s c,
                                               input logic state);
        logic [31:0] image;
        image = `CCL_DATA_ZERO;
        image[`CCL_BIT_ON]                 = c.comparator_on;
        image[`CCL_BIT_IDLE_STOP]          = c.idle_stop;
        image[`CCL_HYS_HI:`CCL_HYS_LO]     = c.hysteresis_level;
        image[`CCL_BIT_FILTER_EN]          = c.filter_enable;
        image[`CCL_BIT_FCLK_SEL]           = c.filter_clock_select;
        image[`CCL_BIT_DAC_OE]             = c.dac_pin_output_enable;
        image[`CCL_INPUT_SOURCE_SELECT_HI:`CCL_INPUT_SOURCE_SELECT_LO] = c.input_source_select;
        image[`CCL_BIT_EXT_REF]            = c.external_reference_select;
        image[`CCL_BIT_HYS_EDGE]           = c.hysteresis_edge;
        image[`CCL_BIT_STATE]              = state;
        image[`CCL_BIT_ALT_INPUT]          = c.alternate_input_select;
        image[`CCL_BIT_INVERT]             = c.output_invert;
        image[`CCL_BIT_RANGE]              = c.dac_range_supply;
        return image;
    endfunction : read_image

    // ************************************************************
    // APB slave
    // ************************************************************
    // No wait state: pready is registered at the setup edge, so every access
    // ends in its first access cycle, with an output straight from a flop.
    assign bus_setup = i_psel && !i_penable;
    assign bus_write = i_psel && i_penable && o_pready && i_pwrite;
    assign addr_hit  = (i_paddr == `CCL_CTRL_ADDR);

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            bus_state <= comparator_control_pkg::BUS_IDLE;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= `CCL_DATA_ZERO;
        end else begin
            case (bus_state)
                comparator_control_pkg::BUS_IDLE: begin
                    if (bus_setup) begin
                        bus_state <= comparator_control_pkg::BUS_ACCESS;
                        o_pready  <= 1'b1;
                        o_pslverr <= !addr_hit;
                        o_prdata  <= (addr_hit && !i_pwrite) ?
                                     read_image(ctrl, polarity_level) : `CCL_DATA_ZERO;
                    end
                end
                comparator_control_pkg::BUS_ACCESS: begin
                    bus_state <= comparator_control_pkg::BUS_IDLE;
                    o_pready  <= 1'b0;
                    o_pslverr <= 1'b0;
                    o_prdata  <= `CCL_DATA_ZERO;
                end
                default: begin
                    bus_state <= comparator_control_pkg::BUS_IDLE;
                    o_pready  <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    // Bit 14 has no storage, so writes to it vanish; bit 3 is status only
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ctrl <= `CCL_CTRL_RESET;
        end else if (bus_write && addr_hit) begin
            if (i_pstrb[`CCL_LANE_HI]) begin
                ctrl.comparator_on         <= i_pwdata[`CCL_BIT_ON];
                ctrl.idle_stop             <= i_pwdata[`CCL_BIT_IDLE_STOP];
                ctrl.hysteresis_level      <= i_pwdata[`CCL_HYS_HI:`CCL_HYS_LO];
                ctrl.filter_enable         <= i_pwdata[`CCL_BIT_FILTER_EN];
                ctrl.filter_clock_select   <= i_pwdata[`CCL_BIT_FCLK_SEL];
                ctrl.dac_pin_output_enable <= i_pwdata[`CCL_BIT_DAC_OE];
            end
            if (i_pstrb[`CCL_LANE_LO]) begin
                ctrl.input_source_select       <= i_pwdata[`CCL_INPUT_SOURCE_SELECT_HI:`CCL_INPUT_SOURCE_SELECT_LO];
                ctrl.external_reference_select <= i_pwdata[`CCL_BIT_EXT_REF];
                ctrl.hysteresis_edge           <= i_pwdata[`CCL_BIT_HYS_EDGE];
                ctrl.alternate_input_select    <= i_pwdata[`CCL_BIT_ALT_INPUT];
                ctrl.output_invert             <= i_pwdata[`CCL_BIT_INVERT];
                ctrl.dac_range_supply          <= i_pwdata[`CCL_BIT_RANGE];
            end
        end
    end

    // ************************************************************
    // Channel enable and analog settings
    // ************************************************************
    // Idle stop from any channel halts this one as well
    assign active = ctrl.comparator_on &&
                    !(i_idle_mode && (ctrl.idle_stop || i_other_idle_stop));

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_comparator_enable <= 1'b0;
            o_idle_stop         <= 1'b0;
            o_analog_config     <= '0;
        end else begin
            o_comparator_enable                       <= active;
            o_idle_stop                               <= ctrl.idle_stop;
            o_analog_config.hysteresis_level          <= ctrl.hysteresis_level;
            o_analog_config.hysteresis_edge           <= ctrl.hysteresis_edge;
            o_analog_config.dac_pin_connect           <= ctrl.dac_pin_output_enable;
            o_analog_config.external_reference_select <= ctrl.external_reference_select;
            o_analog_config.dac_range_supply          <= ctrl.dac_range_supply;
            o_analog_config.input_select              <=
                input_decode(ctrl.alternate_input_select, ctrl.input_source_select);
        end
    end

    // ************************************************************
    // Polarity and pulse stretcher
    // ************************************************************
    // PWM ticks pace stretcher and filter when selected; tick rate sets width
    assign step = ctrl.filter_clock_select ? i_pwm_clock_tick : 1'b1;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            polarity_level <= 1'b0;
        end else begin
            polarity_level <= active && (i_comparator_raw ^ ctrl.output_invert);
        end
    end

    // Reload while high, so the tail counts from the last high sample
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            stretched     <= 1'b0;
            stretch_count <= `CCL_COUNT_ZERO;
        end else if (polarity_level) begin
            stretched     <= 1'b1;
            stretch_count <= `CCL_STRETCH_LOAD;
        end else if (stretch_count != `CCL_COUNT_ZERO) begin
            stretched <= 1'b1;
            if (step) begin
                stretch_count <= stretch_count - `CCL_COUNT_ONE;
            end
        end else begin
            stretched <= 1'b0;
        end
    end

    // ************************************************************
    // Digital filter and output
    // ************************************************************
    comparator_level_filter u_filter (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_step    (step),
        .i_level   (stretched),
        .o_level   (filtered)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_comparator_out <= 1'b0;
        end else begin
            o_comparator_out <= active && (ctrl.filter_enable ? filtered : stretched);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    // Enable and idle halt
    enable_follow_a: assert property (ctrl.comparator_on && !i_idle_mode
        |=> o_comparator_enable) else $error("channel not enabled");
    idle_own_stop_a: assert property (i_idle_mode && ctrl.idle_stop
        |=> !o_comparator_enable) else $error("idle stop ignored");
    idle_any_stop_a: assert property (i_idle_mode && i_other_idle_stop
        |=> !o_comparator_enable) else $error("shared idle stop ignored");
    idle_run_a: assert property (ctrl.comparator_on && !ctrl.idle_stop
        && !i_other_idle_stop |=> o_comparator_enable) else $error("idle run halted");
    idle_flag_out_a: assert property (o_idle_stop == $past(ctrl.idle_stop))
        else $error("idle stop flag not shared");

    // Settings for the analog side run one cycle behind the register
    hysteresis_write_a: assert property (bus_write && addr_hit && i_pstrb[`CCL_LANE_HI]
        |=> ##1 o_analog_config.hysteresis_level == $past(i_pwdata[`CCL_HYS_HI:`CCL_HYS_LO], 2))
        else $error("hysteresis not applied");
    dac_route_a: assert property (o_analog_config.dac_pin_connect
        == $past(ctrl.dac_pin_output_enable)) else $error("dac pin routing wrong");
    reference_select_a: assert property (o_analog_config.external_reference_select
        == $past(ctrl.external_reference_select)) else $error("reference select wrong");
    hysteresis_edge_a: assert property (o_analog_config.hysteresis_edge
        == $past(ctrl.hysteresis_edge)) else $error("hysteresis edge wrong");
    // Range is only carried; software is trusted to keep it set
    range_pass_a: assert property (o_analog_config.dac_range_supply
        == $past(ctrl.dac_range_supply)) else $error("range select wrong");
    pin_select_a: assert property (!ctrl.alternate_input_select
        |=> o_analog_config.input_select == (`CCL_SEL_PIN_A << $past(ctrl.input_source_select)))
        else $error("external pin select wrong");
    amp_select_a: assert property (ctrl.alternate_input_select
        && !ctrl.input_source_select[1]
        |=> o_analog_config.input_select
            == (`CCL_SEL_AMP_1 << $past(ctrl.input_source_select[0])))
        else $error("amplifier select wrong");
    reserved_input_a: assert property (ctrl.alternate_input_select
        && ctrl.input_source_select[1]
        |=> o_analog_config.input_select == `CCL_SEL_NONE) else $error("reserved input used");
    alternate_only_a: assert property (ctrl.alternate_input_select
        |=> (o_analog_config.input_select & (`CCL_SEL_PIN_A | `CCL_SEL_PIN_B
            | `CCL_SEL_PIN_C | `CCL_SEL_PIN_D)) == `CCL_SEL_NONE)
        else $error("alternate mode picked a pin");

    // Read image: status is the polarity stage at the setup edge
    status_read_a: assert property (bus_setup && addr_hit && !i_pwrite
        && bus_state == comparator_control_pkg::BUS_IDLE
        |=> o_prdata[`CCL_BIT_STATE] == $past(polarity_level))
        else $error("status bit stale");
    bit14_zero_a: assert property (o_pready && !i_pwrite
        |-> o_prdata[31:16] == 16'h0000 && !o_prdata[14]) else $error("bit 14 reads one");
    // Register changes only on a write that hits it
    ctrl_hold_a: assert property (!(bus_write && addr_hit)
        |=> ctrl == $past(ctrl)) else $error("register changed without write");

    // Bus answer lasts one cycle; data and error stay low outside it
    pready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held too long");
    idle_data_a: assert property (!o_pready |-> o_prdata == `CCL_DATA_ZERO && !o_pslverr)
        else $error("bus answer outside access");
    pslverr_map_a: assert property (bus_setup && bus_state == comparator_control_pkg::BUS_IDLE
        |=> o_pslverr == !$past(addr_hit))
        else $error("error response wrong");

    // Signal path: polarity, stretcher, filter, output
    polarity_path_a: assert property ($past(active)
        |-> polarity_level == ($past(i_comparator_raw) ^ $past(ctrl.output_invert)))
        else $error("polarity wrong");
    // A PWM-paced tail only shortens on a tick, so slow ticks widen it
    pwm_pacing_a: assert property (ctrl.filter_clock_select && !i_pwm_clock_tick
        && !polarity_level && stretch_count != `CCL_COUNT_ZERO
        |=> stretch_count == $past(stretch_count)) else $error("stretcher ran without tick");
    stretch_width_a: assert property (!ctrl.filter_clock_select && $rose(stretched)
        |-> stretched [*3]) else $error("pulse too short");
    filter_hold_a: assert property ($changed(filtered)
        |-> $past(stretched) == filtered && $past(stretched, 2) == filtered
            && $past(stretched, 3) == filtered) else $error("filter passed early");
    filter_bypass_a: assert property (active && !ctrl.filter_enable
        |=> o_comparator_out == $past(stretched)) else $error("bypass path wrong");
    filter_path_a: assert property (active && ctrl.filter_enable
        |=> o_comparator_out == $past(filtered)) else $error("filter path wrong");
    disabled_quiet_a: assert property (!ctrl.comparator_on
        |=> !o_comparator_out && !polarity_level) else $error("disabled channel active");

    // Main scenarios the bench is expected to reach
    write_seen_c: cover property (bus_write && addr_hit);
    stretch_seen_c: cover property ($rose(stretched) ##3 !stretched);
    filter_pass_c: cover property (ctrl.filter_enable && $rose(filtered));
    idle_halt_c: cover property (ctrl.comparator_on && i_idle_mode && !o_comparator_enable);
    pwm_hold_c: cover property (ctrl.filter_clock_select && !polarity_level && stretched);

endmodule : comparator_control_logic

// ===== tb/comparator_control_logic_test.sv
// Self-checking bench for the comparator channel control block.
// Assumes the design answers APB in one access cycle and runs on one clock.
`timescale 1ns/1ps
`include "comparator_control_map.svh"

module comparator_control_logic_test;
    logic                                clk_sys;
    logic                                reset;
    logic                                psel, penable, pwrite, pready, pslverr;
    logic [`CCL_ADDR_W-1:0]              paddr;
    logic [31:0]                         pwdata, prdata, rd;
    logic [3:0]                          pstrb;
    logic                                idle_mode, other_stop, pwm_tick, raw, err;
    logic                                idle_stop, comp_enable, comp_out;
    comparator_control_pkg::analog_cfg_s analog_cfg;
    int                                  n_errors, samples_checked, model, w, n;

    comparator_control_logic i_comparator_control_logic (
        .i_clk_sys (clk_sys), .i_reset (reset), .i_psel (psel), .i_penable (penable),
        .i_pwrite (pwrite), .i_paddr (paddr), .i_pwdata (pwdata), .i_pstrb (pstrb),
        .o_prdata (prdata), .o_pready (pready), .o_pslverr (pslverr),
        .i_idle_mode (idle_mode), .i_other_idle_stop (other_stop),
        .i_pwm_clock_tick (pwm_tick), .i_comparator_raw (raw), .o_idle_stop (idle_stop),
        .o_comparator_enable (comp_enable), .o_analog_config (analog_cfg),
        .o_comparator_out (comp_out));

    // ************************************************************
    // Clock and shared tasks
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wait_clk(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : wait_clk

    // Model of the analog settings; reserved alternate codes select nothing
    function automatic logic [31:0] exp_cfg(input int v);
        logic [5:0] sel;
        sel = v[2] ? (v[7:6] == 2'b00 ? 6'h10 : (v[7:6] == 2'b01 ? 6'h20 : 6'h00))
                   : (6'h01 << v[7:6]);
        return {20'h00000, v[12:11], v[4], v[8], v[5], v[0], sel};
    endfunction : exp_cfg

    task automatic tally_and_finish;
        $display("errors=%0d comparisons=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #300000;
        n_errors++;
        tally_and_finish();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h00000000; pstrb = 4'hF; idle_mode = 1'b0; other_stop = 1'b0;
        pwm_tick = 1'b0; raw = 1'b0; n_errors = 0; samples_checked = 0;
        void'($urandom(32'hDE55));
        wait_clk(16);
        reset <= 1'b0;
        apb(1'b0, `CCL_CTRL_ADDR, 32'h0, 4'hF);
        check(rd, 32'h0);
        // Random settings with the range bit kept set by software
        for (int i = 0; i < 16; i++) begin
            w = $urandom | 32'h00000001;
            apb(1'b1, `CCL_CTRL_ADDR, w, 4'hF);
            model = w & 32'h0000BFF7;
            wait_clk(3);
            check(analog_cfg, exp_cfg(model));
            check(comp_enable, model[15]);
            check(idle_stop, model[13]);
            apb(1'b0, `CCL_CTRL_ADDR, 32'h0, 4'hF);
            check(rd, model | ((model[15] & model[1]) << 3));
        end
        // Byte lanes: only the strobed lane changes
        apb(1'b1, `CCL_CTRL_ADDR, ~model | 32'h1, 4'h1);
        model = (model & 32'hFF00) | (~model & 32'h00F6) | 32'h1;
        apb(1'b0, `CCL_CTRL_ADDR, 32'h0, 4'hF);
        check(rd, model | ((model[15] & model[1]) << 3));
        // Unmapped word: error response, read zero, write ignored
        apb(1'b1, 12'h004, 32'h0000FFFF, 4'hF);
        check(err, 1'b1);
        apb(1'b0, 12'h004, 32'h0, 4'hF);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b0, `CCL_CTRL_ADDR, 32'h0, 4'hF);
        check(rd, model | ((model[15] & model[1]) << 3));
        // Every enable and idle combination with the comparator high
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, `CCL_CTRL_ADDR, {c[0], 1'b0, c[1], 13'h0001}, 4'hF);
            idle_mode <= c[2]; other_stop <= c[3]; raw <= 1'b1;
            wait_clk(8);
            check(comp_out, c[0] & ~(c[2] & (c[1] | c[3])));
            check(comp_enable, c[0] & ~(c[2] & (c[1] | c[3])));
            apb(1'b0, `CCL_CTRL_ADDR, 32'h0, 4'hF);
            check(rd[3], c[0] & ~(c[2] & (c[1] | c[3])));
        end
        idle_mode <= 1'b0; other_stop <= 1'b0; raw <= 1'b0;
        // Single-cycle pulse, bypass path, system clock
        apb(1'b1, `CCL_CTRL_ADDR, 32'h00008001, 4'hF);
        wait_clk(8);
        raw <= 1'b1;
        @(posedge clk_sys);
        raw <= 1'b0;
        n = 0;
        repeat (15) begin
            @(posedge clk_sys);
            n += comp_out;
        end
        check(n >= 3, 1'b1);
        // Inverted polarity with the comparator low
        apb(1'b1, `CCL_CTRL_ADDR, 32'h00008003, 4'hF);
        wait_clk(8);
        check(comp_out, 1'b1);
        // Filter delays a new level beyond the bypass latency
        apb(1'b1, `CCL_CTRL_ADDR, 32'h00008401, 4'hF);
        wait_clk(10);
        raw <= 1'b1;
        wait_clk(4);
        check(comp_out, 1'b0);
        wait_clk(10);
        check(comp_out, 1'b1);
        raw <= 1'b0;
        wait_clk(15);
        // PWM-paced filter stands still without ticks
        apb(1'b1, `CCL_CTRL_ADDR, 32'h00008601, 4'hF);
        raw <= 1'b1;
        wait_clk(20);
        check(comp_out, 1'b0);
        repeat (12) begin
            pwm_tick <= 1'b1;
            @(posedge clk_sys);
            pwm_tick <= 1'b0;
            @(posedge clk_sys);
        end
        wait_clk(3);
        check(comp_out, 1'b1);
        // Without ticks the stretcher tail never runs out
        raw <= 1'b0;
        wait_clk(6);
        check(comp_out, 1'b1);
        tally_and_finish();
    end
endmodule : comparator_control_logic_test
